// ---- hmc_host.sv ----
// Bus master model that issues register accesses and instructions
`timescale 1ns/1ps
module hmc_host (
    // Clock
    input  wire logic        i_mclk,
    // Bus request
    output logic             o_cyc,
    output logic             o_stb,
    output logic             o_we,
    output logic [7:0]       o_adr,
    output logic [3:0]       o_sel,
    output logic [31:0]      o_dat,
    // Bus answer
    input  wire logic [31:0] i_dat,
    input  wire logic        i_ack
);
    // Idle bus at time zero
    initial
    begin
        o_cyc = 1'b0;
        o_stb = 1'b0;
        o_we  = 1'b0;
        o_adr = 8'h00;
        o_sel = 4'h0;
        o_dat = 32'h0000_0000;
    end

    // One classic cycle, held until ack is sampled high
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, input logic [3:0] sel,
                        output logic [31:0] rd);
        @(posedge i_mclk);
        o_cyc <= 1'b1;
        o_stb <= 1'b1;
        o_we  <= we;
        o_adr <= adr;
        o_sel <= sel;
        o_dat <= wd;
        do @(posedge i_mclk); while (i_ack !== 1'b1);
        rd = i_dat;
        o_cyc <= 1'b0;
        o_stb <= 1'b0;
        o_adr <= ~adr; // Released address, select and data lines do not keep old value
        o_sel <= ~sel;
        o_dat <= ~wd;
    endtask
endmodule // hmc_host

// ---- hmc_mac_if.sv ----
// Operand and result bundle between sequencer and accumulate unit
`timescale 1ns/1ps
interface hmc_mac_if;
    import hmc_pkg::*;
    hmc_mac_t    op;
    logic [31:0] src_a;
    logic [31:0] src_b;
    logic [31:0] acc;
    logic [31:0] res;
    logic        ovf;
    modport core (output op, src_a, src_b, acc, input res, ovf);
    modport unit (input op, src_a, src_b, acc, output res, ovf);
endinterface

// ---- hmc_mac_unit.sv ----
// Combinational halfword multiply with 33-bit accumulate and saturation
`timescale 1ns/1ps
module hmc_mac_unit (
    hmc_mac_if.unit m
);
    import hmc_pkg::*;

    logic [15:0] half_a;
    logic [15:0] half_b;
    logic        sgn;
    logic        sat;
    logic [31:0] opd_a;
    logic [31:0] opd_b;
    logic [31:0] prod;
    logic [32:0] temp;
    logic        s_ovf;

    // Halfword pick, signedness and saturation per kind
    always_comb
    begin
        half_a = m.src_a[15:0];
        half_b = m.src_b[15:0];
        sgn    = 1'b0;
        sat    = 1'b0;
        case (m.op)
            MAC_HHU:
            begin
                half_a = m.src_a[31:16];
                half_b = m.src_b[31:16];
            end
            MAC_LLS:  sgn = 1'b1;
            MAC_LLSS:
            begin
                sgn = 1'b1;
                sat = 1'b1;
            end
            MAC_LLUS: sat = 1'b1;
            MAC_LLU:  sat = 1'b0;
            default:  sat = 1'b0;
        endcase
    end

    // Product and 33-bit sum
    always_comb
    begin
        opd_a = sgn ? {{16{half_a[15]}}, half_a} : {16'h0000, half_a};
        opd_b = sgn ? {{16{half_b[15]}}, half_b} : {16'h0000, half_b};
        prod  = opd_a * opd_b;
        temp  = {1'b0, prod} + {1'b0, m.acc};
        s_ovf = (prod[31] == m.acc[31]) && (m.acc[31] != temp[31]);
        m.ovf = sgn ? s_ovf : temp[32];
        if (sat && sgn && s_ovf)
            m.res = m.acc[31] ? SAT_S_MIN : SAT_S_MAX;
        else if (sat && !sgn && temp[32])
            m.res = SAT_U_MAX;
        else
            m.res = temp[31:0];
    end

endmodule // hmc_mac_unit

// ---- hmc_pkg.sv ----
// Constants, types and register map of the halfword multiply-accumulate datapath
package hmc_pkg;

    // Bus geometry and register byte offsets
    localparam int          ADR_W      = 8;
    localparam logic [7:0]  OFF_INSN   = 8'h00;
    localparam logic [7:0]  OFF_SRC_A  = 8'h04;
    localparam logic [7:0]  OFF_SRC_B  = 8'h08;
    localparam logic [7:0]  OFF_ACC    = 8'h0c;
    localparam logic [7:0]  OFF_COND   = 8'h10;
    localparam logic [7:0]  OFF_FXER   = 8'h14;
    localparam logic [7:0]  OFF_STS    = 8'h18;
    localparam logic [7:0]  OFF_MASK   = 8'h1c;

    // Reset values
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;
    localparam logic [2:0]  RST_EVT    = 3'h0;

    // Saturation limits
    localparam logic [31:0] SAT_U_MAX  = 32'hffff_ffff;
    localparam logic [31:0] SAT_S_MAX  = 32'h7fff_ffff;
    localparam logic [31:0] SAT_S_MIN  = 32'h8000_0000;

    // Exception register and first condition field bit positions
    localparam int          FX_SO      = 31;
    localparam int          FX_WRAP    = 30;
    localparam int          FCF_LSB    = 28;

    // Status and mask bit positions
    localparam int          EV_DONE    = 0;
    localparam int          EV_OVF     = 1;
    localparam int          EV_ILL     = 2;

    // Instruction encodings
    localparam logic [5:0]  OP_MAC     = 6'h04;
    localparam logic [5:0]  OP_CRL     = 6'h13;
    localparam logic [5:0]  OP_EXT     = 6'h1f;
    localparam logic [8:0]  XO_HHU     = 9'h00c;
    localparam logic [8:0]  XO_LLS     = 9'h1ac;
    localparam logic [8:0]  XO_LLSS    = 9'h1ec;
    localparam logic [8:0]  XO_LLUS    = 9'h1cc;
    localparam logic [8:0]  XO_LLU     = 9'h18c;
    localparam logic [9:0]  XO_FMOVE   = 10'h000;
    localparam logic [9:0]  XO_XMOVE   = 10'h200;

    // Accumulate kinds
    typedef enum logic [2:0] {
        MAC_NONE, MAC_HHU, MAC_LLS, MAC_LLSS, MAC_LLUS, MAC_LLU
    } hmc_mac_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } hmc_state_t;

endpackage

// ---- hmc_top.sv ----
// Wishbone-attached multiply-accumulate and condition-field move datapath
`timescale 1ns/1ps
module hmc_top (
    // Clock and reset
    input  wire logic                       i_mclk,
    input  wire logic                       i_rst_n,
    // Wishbone slave
    input  wire logic                       i_wb_cyc,
    input  wire logic                       i_wb_stb,
    input  wire logic                       i_wb_we,
    input  wire logic [hmc_pkg::ADR_W-1:0]  i_wb_adr,
    input  wire logic [3:0]                 i_wb_sel,
    input  wire logic [31:0]                i_wb_dat,
    output logic      [31:0]                o_wb_dat,
    output logic                            o_wb_ack,
    // Interrupt
    output logic                            o_irq
);
    import hmc_pkg::*;

    // Byte-lane merge of a bus write
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
            if (sel[i])
                r[8*i +: 8] = new_v[8*i +: 8];
        return r;
    endfunction

    // Four-bit condition field at a bit position
    function automatic logic [3:0] fld(input logic [31:0] v, input logic [4:0] lsb);
        return v[lsb +: 4];
    endfunction

    // Registers
    logic [31:0] insn_q, insn_d;
    logic [31:0] src_a_reg_q, src_a_reg_d;
    logic [31:0] acc_q, acc_d;
    logic [31:0] src_b_reg_q, src_b_reg_d;
    logic [31:0] condition_register_q, condition_register_d;
    logic [31:0] fixed_point_exception_register_q, fixed_point_exception_register_d;
    logic [2:0]  sts_q, sts_d;
    logic [2:0]  msk_q, msk_d;
    logic        ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic        irq_q, irq_d;
    hmc_state_t  state_q, state_d;

    // Decode wires
    logic        commit;
    logic [5:0]  prim_op;
    logic [8:0]  xo9;
    logic [9:0]  xo10;
    logic        oe_flag;
    logic        record_flag;
    logic [4:0]  dest_lsb;
    logic [4:0]  src_lsb;
    logic        is_fmove;
    logic        is_xmove;
    hmc_mac_t    mac_op;
    logic [2:0]  ev;
    logic        so_now;
    logic [3:0]  first_condition_field;

    hmc_mac_if mac_bus ();

    hmc_mac_unit u_mac (
        .m (mac_bus)
    );

    // Operands to the accumulate unit
    assign mac_bus.op    = mac_op;
    assign mac_bus.src_a = src_a_reg_q;
    assign mac_bus.src_b = src_b_reg_q;
    assign mac_bus.acc   = acc_q;

    // Instruction fields; reserved bits are never examined
    always_comb
    begin
        prim_op     = insn_q[31:26];
        xo9         = insn_q[9:1];
        xo10        = insn_q[10:1];
        oe_flag     = insn_q[10];
        record_flag = insn_q[0];
        dest_lsb    = {~insn_q[25:23], 2'b00}; // Field n sits at 4*(7-n)
        src_lsb     = {~insn_q[20:18], 2'b00};
        is_fmove    = (prim_op == OP_CRL) && (xo10 == XO_FMOVE);
        is_xmove    = (prim_op == OP_EXT) && (xo10 == XO_XMOVE);
        mac_op      = MAC_NONE;
        if (prim_op == OP_MAC)
        begin
            case (xo9)
                XO_HHU:  mac_op = MAC_HHU;
                XO_LLS:  mac_op = MAC_LLS;
                XO_LLSS: mac_op = MAC_LLSS;
                XO_LLUS: mac_op = MAC_LLUS;
                XO_LLU:  mac_op = MAC_LLU;
                default: mac_op = MAC_NONE;
            endcase
        end
    end

    // Bus handshake: ack one cycle after request, write at ack edge
    always_comb
    begin
        ack_d  = i_wb_cyc && i_wb_stb && !ack_q;
        commit = i_wb_cyc && i_wb_stb && ack_q && i_wb_we;
        rdat_d = rdat_q;
        if (ack_d && !i_wb_we)
        begin
            case (i_wb_adr)
                OFF_INSN:  rdat_d = insn_q;
                OFF_SRC_A: rdat_d = src_a_reg_q;
                OFF_SRC_B: rdat_d = src_b_reg_q;
                OFF_ACC:   rdat_d = acc_q;
                OFF_COND:  rdat_d = condition_register_q;
                OFF_FXER:  rdat_d = fixed_point_exception_register_q;
                OFF_STS:   rdat_d = {29'h0, sts_q};
                OFF_MASK:  rdat_d = {29'h0, msk_q};
                default:   rdat_d = RST_WORD;
            endcase
        end
    end

    // Sequencer, register writes and instruction effects
    always_comb
    begin
        insn_d                           = insn_q;
        src_a_reg_d                      = src_a_reg_q;
        src_b_reg_d                      = src_b_reg_q;
        acc_d                            = acc_q;
        condition_register_d             = condition_register_q;
        fixed_point_exception_register_d = fixed_point_exception_register_q;
        msk_d                            = msk_q;
        state_d                          = state_q;
        ev                               = RST_EVT;
        so_now                           = fixed_point_exception_register_q[FX_SO];
        first_condition_field            = 4'h0;
        // Software writes
        if (commit)
        begin
            case (i_wb_adr)
                OFF_INSN:  insn_d = lane_merge(insn_q, i_wb_dat, i_wb_sel);
                OFF_SRC_A: src_a_reg_d = lane_merge(src_a_reg_q, i_wb_dat, i_wb_sel);
                OFF_SRC_B: src_b_reg_d = lane_merge(src_b_reg_q, i_wb_dat, i_wb_sel);
                OFF_ACC:   acc_d = lane_merge(acc_q, i_wb_dat, i_wb_sel);
                OFF_COND:  condition_register_d = lane_merge(condition_register_q, i_wb_dat, i_wb_sel);
                OFF_FXER:  fixed_point_exception_register_d =
                               lane_merge(fixed_point_exception_register_q, i_wb_dat, i_wb_sel);
                OFF_MASK:  msk_d = i_wb_sel[0] ? i_wb_dat[2:0] : msk_q;
                default:   msk_d = msk_q;
            endcase
        end
        case (state_q)
            ST_IDLE:
            begin
                if (commit && (i_wb_adr == OFF_INSN))
                    state_d = ST_EXEC;
            end
            ST_EXEC:
            begin
                state_d = ST_IDLE;
                if (mac_op != MAC_NONE)
                begin
                    acc_d        = mac_bus.res;
                    ev[EV_DONE]  = 1'b1;
                    ev[EV_OVF]   = mac_bus.ovf;
                    if (oe_flag)
                    begin
                        fixed_point_exception_register_d[FX_WRAP] = mac_bus.ovf;
                        so_now = fixed_point_exception_register_q[FX_SO] | mac_bus.ovf;
                        fixed_point_exception_register_d[FX_SO] = so_now;
                    end
                    if (record_flag)
                    begin
                        // Signed compare of the written value with zero
                        first_condition_field[3] = mac_bus.res[31];
                        first_condition_field[2] = !mac_bus.res[31] && (mac_bus.res != RST_WORD);
                        first_condition_field[1] = (mac_bus.res == RST_WORD);
                        first_condition_field[0] = so_now;
                        condition_register_d[FCF_LSB +: 4] = first_condition_field;
                    end
                end
                else if (is_fmove)
                begin
                    condition_register_d[dest_lsb +: 4] = fld(condition_register_q, src_lsb);
                    ev[EV_DONE] = 1'b1;
                end
                else if (is_xmove)
                begin
                    condition_register_d[dest_lsb +: 4] = fixed_point_exception_register_q[31:28];
                    fixed_point_exception_register_d[31:28] = 4'h0;
                    ev[EV_DONE] = 1'b1;
                end
                else
                    ev[EV_ILL] = 1'b1;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Sticky status, write-one-to-clear, a new event wins over the clear
    always_comb
    begin
        sts_d = sts_q;
        if (commit && (i_wb_adr == OFF_STS) && i_wb_sel[0])
            sts_d = sts_q & ~i_wb_dat[2:0];
        sts_d = sts_d | ev;
        irq_d = |(sts_d & msk_d);
    end

    // State registers
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            insn_q                           <= RST_WORD;
            src_a_reg_q                      <= RST_WORD;
            src_b_reg_q                      <= RST_WORD;
            acc_q                            <= RST_WORD;
            condition_register_q             <= RST_WORD;
            fixed_point_exception_register_q <= RST_WORD;
            sts_q                            <= RST_EVT;
            msk_q                            <= RST_EVT;
            ack_q                            <= 1'b0;
            rdat_q                           <= RST_WORD;
            irq_q                            <= 1'b0;
            state_q                          <= ST_IDLE;
        end
        else
        begin
            insn_q                           <= insn_d;
            src_a_reg_q                      <= src_a_reg_d;
            src_b_reg_q                      <= src_b_reg_d;
            acc_q                            <= acc_d;
            condition_register_q             <= condition_register_d;
            fixed_point_exception_register_q <= fixed_point_exception_register_d;
            sts_q                            <= sts_d;
            msk_q                            <= msk_d;
            ack_q                            <= ack_d;
            rdat_q                           <= rdat_d;
            irq_q                            <= irq_d;
            state_q                          <= state_d;
        end
    end

    // Outputs straight from flops
    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;
    assign o_irq    = irq_q;

    // Reference values for the checks below
    logic        in_exec;
    logic [31:0] exp_hhu;
    logic [31:0] exp_lls;
    logic [31:0] exp_llu;
    logic [32:0] sum_llu;
    logic [31:0] prod_lls;
    logic        lls_ovf;
    logic [31:0] exp_clamp;
    logic [3:0]  exp_fmove;
    logic [3:0]  fxer_top;

    always_comb
    begin
        in_exec   = (state_q == ST_EXEC);
        exp_hhu   = {16'h0000, src_a_reg_q[31:16]} * {16'h0000, src_b_reg_q[31:16]} + acc_q;
        prod_lls  = {{16{src_a_reg_q[15]}}, src_a_reg_q[15:0]} * {{16{src_b_reg_q[15]}}, src_b_reg_q[15:0]};
        exp_lls   = prod_lls + acc_q;
        sum_llu   = {1'b0, {16'h0000, src_a_reg_q[15:0]} * {16'h0000, src_b_reg_q[15:0]}} + {1'b0, acc_q};
        exp_llu   = sum_llu[31:0];
        lls_ovf   = (prod_lls[31] == acc_q[31]) && (exp_lls[31] != acc_q[31]);
        exp_clamp = acc_q[31] ? SAT_S_MIN : SAT_S_MAX;
        exp_fmove = fld(condition_register_q, src_lsb);
        fxer_top  = fixed_point_exception_register_q[31:28];
    end

    property p_hhu_mod;
        @(posedge i_mclk) disable iff (!i_rst_n)
        in_exec && (mac_op == MAC_HHU) |=> acc_q == $past(exp_hhu);
    endproperty
    a_hhu_mod: assert property (p_hhu_mod) else $error("high-high modulo sum wrong");

    property p_lls_mod;
        @(posedge i_mclk) disable iff (!i_rst_n)
        in_exec && (mac_op == MAC_LLS) |=> acc_q == $past(exp_lls);
    endproperty
    a_lls_mod: assert property (p_lls_mod) else $error("low signed modulo sum wrong");

    property p_llu_mod;
        @(posedge i_mclk) disable iff (!i_rst_n)
        in_exec && (mac_op == MAC_LLU) |=> acc_q == $past(exp_llu);
    endproperty
    a_llu_mod: assert property (p_llu_mod) else $error("low unsigned modulo sum wrong");

    property p_sat_signed;
        @(posedge i_mclk) disable iff (!i_rst_n)
        in_exec && (mac_op == MAC_LLSS) |=> acc_q == ($past(lls_ovf) ? $past(exp_clamp) : $past(exp_lls));
    endproperty
    a_sat_signed: assert property (p_sat_signed) else $error("signed saturation wrong");

    property p_sat_unsigned;
        @(posedge i_mclk) disable iff (!i_rst_n)
        in_exec && (mac_op == MAC_LLUS) |=> acc_q == ($past(sum_llu[32]) ? SAT_U_MAX : $past(exp_llu));
    endproperty
    a_sat_unsigned: assert property (p_sat_unsigned) else $error("unsigned saturation wrong");

    property p_record;
        @(posedge i_mclk) disable iff (!i_rst_n)
        in_exec && (mac_op != MAC_NONE) && record_flag |=>
            (condition_register_q[FCF_LSB+1] == (acc_q == RST_WORD))
            && (condition_register_q[FCF_LSB+2] == (!acc_q[31] && (acc_q != RST_WORD)))
            && (condition_register_q[FCF_LSB+3] == acc_q[31])
            && (condition_register_q[FCF_LSB] == fixed_point_exception_register_q[FX_SO]);
    endproperty
    a_record: assert property (p_record) else $error("first condition field not updated");

    property p_oe_flags;
        @(posedge i_mclk) disable iff (!i_rst_n)
        in_exec && (mac_op != MAC_NONE) && oe_flag && mac_bus.ovf |=>
            fixed_point_exception_register_q[FX_WRAP] && fixed_point_exception_register_q[FX_SO];
    endproperty
    a_oe_flags: assert property (p_oe_flags) else $error("overflow flags not set");

    property p_fmove;
        @(posedge i_mclk) disable iff (!i_rst_n)
        in_exec && (mac_op == MAC_NONE) && is_fmove |=>
            fld(condition_register_q, $past(dest_lsb)) == $past(exp_fmove);
    endproperty
    a_fmove: assert property (p_fmove) else $error("field move wrong");

    property p_xmove;
        @(posedge i_mclk) disable iff (!i_rst_n)
        in_exec && (mac_op == MAC_NONE) && !is_fmove && is_xmove |=>
            (fld(condition_register_q, $past(dest_lsb)) == $past(fxer_top)) && (fxer_top == 4'h0);
    endproperty
    a_xmove: assert property (p_xmove) else $error("exception move wrong");

endmodule // hmc_top

// ---- hmc_top_bench.sv ----
// Self-checking bench for the accumulate and field-move datapath
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
    begin \
        total_checks++; \
        if ((gt) !== (ex)) \
        begin \
            miscompares++; \
            $display("wrong value %s expected %h seen %h", nm, ex, gt); \
        end \
    end
module hmc_top_bench;
    import hmc_pkg::*;
    logic        i_mclk;
    logic        i_rst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic        irq;
    logic [31:0] cond_exp;
    logic [31:0] fxer_exp;
    int          miscompares;
    int          total_checks;

    // Clock at 20 MHz
    initial
    begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    // Design and bus master
    hmc_top dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq));
    hmc_host host (.i_mclk(i_mclk), .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel),
        .o_dat(wdat), .i_dat(rdat), .i_ack(ack));

    // Register access helpers
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic [31:0] junk;
        host.xfer(1'b1, a, d, s, junk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input string nm);
        logic [31:0] got;
        host.xfer(1'b0, a, 32'h0000_0000, 4'hf, got);
        `CHK(nm, ex, got)
    endtask

    // Run one accumulate and compare against the reference result
    task automatic mac(input logic [8:0] xo, input logic oe, input logic rec, input logic [31:0] a, b, d);
        logic [31:0] p;
        logic [32:0] t;
        logic [31:0] r;
        logic        v;
        wr(OFF_SRC_A, a);
        wr(OFF_SRC_B, b);
        wr(OFF_ACC, d);
        wr(OFF_INSN, {OP_MAC, 15'h0000, oe, xo, rec});
        if (xo == XO_HHU)
            p = a[31:16] * b[31:16];
        else if (xo == XO_LLS || xo == XO_LLSS)
            p = $signed(a[15:0]) * $signed(b[15:0]);
        else
            p = a[15:0] * b[15:0];
        t = {1'b0, p} + {1'b0, d};
        r = t[31:0];
        v = (xo == XO_LLS || xo == XO_LLSS) ? (p[31] == d[31] && t[31] != d[31]) : t[32];
        if (xo == XO_LLSS && v)
            r = d[31] ? SAT_S_MIN : SAT_S_MAX;
        if (xo == XO_LLUS && v)
            r = SAT_U_MAX;
        if (oe)
            fxer_exp[31:30] = {fxer_exp[31] | v, v};
        if (rec)
            cond_exp[31:28] = {r[31], !r[31] && r != 0, r == 0, fxer_exp[31]};
        rdc(OFF_ACC, r, "acc");
        rdc(OFF_COND, cond_exp, "cond");
        rdc(OFF_FXER, fxer_exp, "fxer");
    endtask

    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge i_mclk);
        miscompares++;
        finish_test();
    end

    // Test sequence
    initial
    begin
        miscompares = 0;
        total_checks = 0;
        cond_exp = 32'h0000_0000;
        fxer_exp = 32'h0000_0000;
        i_rst_n = 1'b0;
        repeat (6) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        rdc(OFF_COND, RST_WORD, "cond rst");
        rdc(OFF_STS, RST_WORD, "sts rst");
        wr(8'h20, 32'hffff_ffff);
        rdc(8'h20, 32'h0000_0000, "unmapped");
        wr(OFF_SRC_A, 32'h1111_1111);
        wr(OFF_SRC_A, 32'haabb_ccdd, 4'h5);
        rdc(OFF_SRC_A, 32'h11bb_11dd, "byte lanes");
        $display("test reset done");
        mac(XO_HHU, 1'b1, 1'b1, 32'hffff_1234, 32'hffff_5678, 32'h0002_0000);
        mac(XO_LLS, 1'b0, 1'b1, 32'h1234_8000, 32'h0000_8000, 32'h4000_0000);
        mac(XO_LLSS, 1'b1, 1'b1, 32'h0000_8000, 32'h0000_8000, 32'h4000_0000);
        mac(XO_LLSS, 1'b1, 1'b0, 32'h0000_7fff, 32'h0000_8000, 32'h8000_0000);
        mac(XO_LLUS, 1'b1, 1'b1, 32'h0000_ffff, 32'h0000_ffff, 32'h0002_0000);
        mac(XO_LLU, 1'b0, 1'b1, 32'h0000_0003, 32'h0000_0005, 32'hffff_fff1);
        mac(XO_LLUS, 1'b1, 1'b1, 32'h0000_0002, 32'h0000_0003, 32'h0000_0001);
        $display("test accumulate done");
        wr(OFF_COND, 32'h1234_5678);
        wr(OFF_INSN, {OP_CRL, 3'h6, 2'b00, 3'h3, 18'h00000});
        rdc(OFF_COND, 32'h1234_5648, "field move");
        wr(OFF_INSN, {OP_CRL, 3'h0, 2'b11, 3'h7, 18'h00000});
        rdc(OFF_COND, 32'h8234_5648, "reserved bits");
        wr(OFF_FXER, 32'ha000_00ff);
        wr(OFF_INSN, {OP_EXT, 3'h2, 12'h000, XO_XMOVE, 1'b0});
        rdc(OFF_COND, 32'h82a4_5648, "xer move cond");
        rdc(OFF_FXER, 32'h0000_00ff, "xer move clear");
        $display("test moves done");
        `CHK("irq masked", 1'b0, irq)
        wr(OFF_INSN, 32'hfc00_0000);
        rdc(OFF_STS, 32'h0000_0007, "status");
        wr(OFF_MASK, 32'h0000_0004);
        rdc(OFF_MASK, 32'h0000_0004, "mask");
        `CHK("irq set", 1'b1, irq)
        wr(OFF_STS, 32'h0000_0004);
        rdc(OFF_STS, 32'h0000_0003, "status clear");
        `CHK("irq clear", 1'b0, irq)
        $display("test interrupt done");
        finish_test();
    end
endmodule // hmc_top_bench
